//--- vts_pkg.sv
// ****************************************************************
// Shared constants, types and table functions
// ****************************************************************
package vts_pkg;

    // Host register offsets
    localparam logic [7:0] VTS_ADDR_SYS_CFG   = 8'hA0;
    localparam logic [7:0] VTS_ADDR_VOUT_CMD  = 8'hA6;
    localparam logic [7:0] VTS_ADDR_OFFSET    = 8'hA8;
    localparam logic [7:0] VTS_ADDR_PROTOCOL  = 8'hC2;
    localparam logic [7:0] VTS_ADDR_STORE_ALL = 8'h15;

    // Voltage-ID port register offsets
    localparam logic [7:0] VTS_VID_ADDR_BOOT   = 8'h26;
    localparam logic [7:0] VTS_VID_ADDR_OFFSET = 8'h33;

    // Field positions
    localparam int VTS_CFG_SEL_LSB    = 0;
    localparam int VTS_PROTO_STEP_LSB = 0;
    localparam int VTS_PROTO_BOOT_LSB = 4;

    // Reset values
    localparam logic [7:0] VTS_SYS_CFG_RST  = 8'h00;
    localparam logic [7:0] VTS_VOUT_CMD_RST = 8'h00;
    localparam logic [7:0] VTS_OFFSET_RST   = 8'h00;
    localparam logic [7:0] VTS_PROTOCOL_RST = 8'h00;

    // Lowest legal output-target code (0.25 V or 0.50 V)
    localparam logic [7:0] VTS_VOUT_MIN_CODE = 8'h01;
    // Highest boot code that needs the fine step
    localparam logic [3:0] VTS_BOOT_FINE_MAX = 4'hC;

    // Target source selector
    typedef enum logic [1:0] {
        VTS_SRC_VID      = 2'b00,
        VTS_SRC_VID_HOST = 2'b01,
        VTS_SRC_HOST     = 2'b10,
        VTS_SRC_HOST_ALT = 2'b11
    } vts_src_type;

    // Step size select codes
    localparam logic [1:0] VTS_STEP_COARSE_A = 2'b00;
    localparam logic [1:0] VTS_STEP_COARSE_B = 2'b11;

    // Voltage-ID request kinds
    typedef enum logic [1:0] {
        VTS_VID_NONE   = 2'b00,
        VTS_VID_SETV   = 2'b01,
        VTS_VID_SET_WORKING_POINT_CMD  = 2'b10,
        VTS_VID_REGWR  = 2'b11
    } vts_vid_kind_type;

    // Conversion state, Gray along off, ramp, run
    typedef enum logic [1:0] {
        VTS_ST_OFF  = 2'b00,
        VTS_ST_RAMP = 2'b01,
        VTS_ST_RUN  = 2'b11
    } vts_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } vts_host_req_type;

    typedef struct packed {
        vts_vid_kind_type kind;
        logic [7:0]       addr;
        logic [7:0]       data;
    } vts_vid_req_type;

    typedef struct packed {
        logic [3:0] boot;
        logic [1:0] step;
        logic [7:0] vout_cmd;
        logic [7:0] offset;
    } vts_nvm_image_type;

    // Boot field to output code
    function automatic logic [7:0] vts_boot_code(input logic [3:0] boot);
        logic [7:0] code;
        code = 8'h00;
        case (boot)
            4'h1: code = 8'h65;
            4'h2: code = 8'h6F;
            4'h3: code = 8'h79;
            4'h4: code = 8'h83;
            4'h5: code = 8'h8D;
            4'h6: code = 8'h97;
            4'h7: code = 8'hA1;
            4'h8: code = 8'hAB;
            4'h9: code = 8'hAF;
            4'hA: code = 8'hC9;
            4'hB: code = 8'hDD;
            4'hC: code = 8'hFB;
            4'hD: code = 8'h6F;
            4'hE: code = 8'h79;
            4'hF: code = 8'h83;
            default: code = 8'h00;
        endcase
        return code;
    endfunction

    // Boot value must match the step size
    function automatic logic vts_boot_fits(input logic [3:0] boot, input logic [1:0] step);
        logic coarse;
        coarse = (step == VTS_STEP_COARSE_A) || (step == VTS_STEP_COARSE_B);
        if (boot == 4'h0) begin
            return 1'b1;
        end
        return (boot <= VTS_BOOT_FINE_MAX) ? !coarse : coarse;
    endfunction

endpackage

//--- vts_core.sv
`timescale 1ns/1ps
// What this block does
// - Selector picks VID, VID plus offset, host
// - Selector latched at enable; changes wait toggle
// - VID modes start from boot field value
// - VID modes: target writes acked, discarded
// - Mode 00: offset write gets not-acknowledge
// - Mode 01: VID offset writes acked, ignored
// - Mode 01: new host offset applies next start
// - Host mode: VID set commands, offset ignored
// - Boot field write copies into VID boot
// - Store-all saves boot, target, offset to memory
// - Power-on loads stored boot into both places
// - Host mode starts from restored target
// - Host mode starts from target register
// - Fine step: target 0.25 to 1.52 V
// - Coarse step: target 0.50 to 3.04 V
// - Host mode run: target follows accepted writes one cycle after they land
// - Boot not fitting step size is refused
module vts_core (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_nrst,
    // Conversion control
    input  wire logic                       i_en,
    input  wire logic                       i_ramp_done,
    input  wire logic [7:0]                 i_max_id_limit,
    // Host register port
    input  wire vts_pkg::vts_host_req_type  i_host_req,
    output logic                            o_host_ack,
    output logic                            o_host_nack,
    output logic [7:0]                      o_host_rdata,
    // Voltage-ID port
    input  wire vts_pkg::vts_vid_req_type   i_vid_req,
    output logic                            o_vid_ack,
    output logic [7:0]                      o_vid_boot,
    // Nonvolatile memory
    input  wire vts_pkg::vts_nvm_image_type i_nvm_image,
    output logic                            o_nvm_wr,
    output vts_pkg::vts_nvm_image_type      o_nvm_image,
    // Regulation target
    output logic [7:0]                      o_target,
    output logic [7:0]                      o_target_offset,
    output vts_pkg::vts_src_type            o_src_mode,
    output vts_pkg::vts_state_type          o_state
);
    import vts_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]    cfg_reg;
    logic [7:0]    vout_cmd_reg;
    logic [7:0]    offset_reg;
    logic [7:0]    proto_reg;
    logic [7:0]    vid_boot_reg;
    logic [7:0]    vid_offset_reg;
    logic [7:0]    start_offset_reg;
    vts_src_type   mode_reg;
    vts_state_type state_reg;
    logic          en_d_reg;
    logic          por_done_reg;
    logic [7:0]    target_reg;
    logic [7:0]    toffset_reg;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    logic        en_rise;
    logic        host_take;
    logic        host_wr;
    logic        vid_take;
    logic        wr_ok;
    logic        vid_set;
    vts_src_type active_mode;
    vts_src_type cfg_sel;
    logic [3:0]  wr_boot;
    logic [1:0]  wr_step;
    logic [7:0]  vid_clamped;

    // No start before the stored image is back, even with enable already high
    assign en_rise     = por_done_reg && i_en && !en_d_reg;
    assign cfg_sel     = vts_src_type'(cfg_reg[VTS_CFG_SEL_LSB +: 2]);
    // Live selector only while disabled; enabled runs on the latched copy
    assign active_mode = en_d_reg ? mode_reg : cfg_sel;
    // Nothing is taken until the stored image is back
    assign host_take   = por_done_reg && (i_host_req.wr || i_host_req.rd);
    assign host_wr     = por_done_reg && i_host_req.wr;
    assign vid_take    = por_done_reg && (i_vid_req.kind != VTS_VID_NONE);
    assign vid_set     = vid_take && (i_vid_req.kind == VTS_VID_SETV || i_vid_req.kind == VTS_VID_SET_WORKING_POINT_CMD);
    assign wr_boot     = i_host_req.data[VTS_PROTO_BOOT_LSB +: 4];
    assign wr_step     = i_host_req.data[VTS_PROTO_STEP_LSB +: 2];
    assign vid_clamped = (i_vid_req.data > i_max_id_limit) ? i_max_id_limit : i_vid_req.data;

    // Acceptance of a host write per address and mode
    always_comb begin
        wr_ok = 1'b0;
        case (i_host_req.addr)
            VTS_ADDR_SYS_CFG:   wr_ok = 1'b1;
            VTS_ADDR_VOUT_CMD:  wr_ok = (i_host_req.data >= VTS_VOUT_MIN_CODE);
            VTS_ADDR_OFFSET:    wr_ok = (active_mode != VTS_SRC_VID);
            VTS_ADDR_PROTOCOL:  wr_ok = vts_boot_fits(wr_boot, wr_step);
            VTS_ADDR_STORE_ALL: wr_ok = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // Host answers
    // ****************************************************************
    // One-cycle ack or nack, read data held until the next read
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_host_ack   <= 1'b0;
            o_host_nack  <= 1'b0;
            o_host_rdata <= 8'h00;
        end else begin
            o_host_ack  <= 1'b0;
            o_host_nack <= 1'b0;
            if (host_wr) begin
                o_host_ack  <= wr_ok;
                o_host_nack <= !wr_ok;
            end else if (host_take) begin
                o_host_ack  <= 1'b1;
                case (i_host_req.addr)
                    VTS_ADDR_SYS_CFG:  o_host_rdata <= cfg_reg;
                    VTS_ADDR_VOUT_CMD: o_host_rdata <= vout_cmd_reg;
                    VTS_ADDR_OFFSET:   o_host_rdata <= offset_reg;
                    VTS_ADDR_PROTOCOL: o_host_rdata <= proto_reg;
                    default: begin
                        o_host_ack   <= 1'b0;
                        o_host_nack  <= 1'b1;
                        o_host_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Host registers and power-on restore
    // ****************************************************************
    // First edge after release pulls the stored image back in
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            por_done_reg <= 1'b0;
            cfg_reg      <= VTS_SYS_CFG_RST;
            vout_cmd_reg <= VTS_VOUT_CMD_RST;
            offset_reg   <= VTS_OFFSET_RST;
            proto_reg    <= VTS_PROTOCOL_RST;
        end else if (!por_done_reg) begin
            por_done_reg <= 1'b1;
            proto_reg    <= {i_nvm_image.boot, 2'b00, i_nvm_image.step};
            vout_cmd_reg <= i_nvm_image.vout_cmd;
            offset_reg   <= i_nvm_image.offset;
        end else if (host_wr && wr_ok) begin
            case (i_host_req.addr)
                VTS_ADDR_SYS_CFG: cfg_reg <= i_host_req.data;
                VTS_ADDR_VOUT_CMD: begin
                    // VID-driven modes drop the value outright
                    if (active_mode[1]) begin
                        vout_cmd_reg <= i_host_req.data;
                    end
                end
                VTS_ADDR_OFFSET:   offset_reg <= i_host_req.data;
                VTS_ADDR_PROTOCOL: proto_reg  <= i_host_req.data;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Voltage-ID registers
    // ****************************************************************
    // Boot mirror follows the host field; offset only counts in mode 00
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            vid_boot_reg   <= 8'h00;
            vid_offset_reg <= 8'h00;
            o_vid_ack      <= 1'b0;
        end else begin
            o_vid_ack <= vid_take; // every request is acknowledged
            if (!por_done_reg) begin
                vid_boot_reg <= vts_boot_code(i_nvm_image.boot);
            end else if (host_wr && wr_ok && i_host_req.addr == VTS_ADDR_PROTOCOL) begin
                vid_boot_reg <= vts_boot_code(wr_boot);
            end
            if (vid_take && i_vid_req.kind == VTS_VID_REGWR && i_vid_req.addr == VTS_VID_ADDR_OFFSET &&
                active_mode == VTS_SRC_VID) begin
                vid_offset_reg <= i_vid_req.data;
            end
        end
    end

    // ****************************************************************
    // Nonvolatile store
    // ****************************************************************
    // Image snapshots the values current at the command
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_nvm_wr    <= 1'b0;
            o_nvm_image <= '0;
        end else begin
            o_nvm_wr <= 1'b0;
            if (host_wr && i_host_req.addr == VTS_ADDR_STORE_ALL) begin
                o_nvm_wr             <= 1'b1;
                o_nvm_image.boot     <= proto_reg[VTS_PROTO_BOOT_LSB +: 4];
                o_nvm_image.step     <= proto_reg[VTS_PROTO_STEP_LSB +: 2];
                o_nvm_image.vout_cmd <= vout_cmd_reg;
                o_nvm_image.offset   <= offset_reg;
            end
        end
    end

    // ****************************************************************
    // Selector latch and conversion state
    // ****************************************************************
    // Mode frozen from enable rise until enable drops again
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            en_d_reg  <= 1'b0;
            mode_reg  <= VTS_SRC_VID;
            state_reg <= VTS_ST_OFF;
        end else begin
            en_d_reg <= i_en && por_done_reg; // Enable seen only after restore
            if (en_rise) begin
                mode_reg <= cfg_sel;
            end
            case (state_reg)
                VTS_ST_OFF:  if (en_rise) state_reg <= VTS_ST_RAMP;
                VTS_ST_RAMP: if (!i_en) state_reg <= VTS_ST_OFF;
                             else if (i_ramp_done) state_reg <= VTS_ST_RUN;
                VTS_ST_RUN:  if (!i_en) state_reg <= VTS_ST_OFF;
                default:     state_reg <= VTS_ST_OFF;
            endcase
        end
    end

    // ****************************************************************
    // Regulation target
    // ****************************************************************
    // Start values at enable rise, then per-mode tracking while running
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            target_reg       <= 8'h00;
            toffset_reg      <= 8'h00;
            start_offset_reg <= 8'h00;
        end else if (!i_en) begin
            target_reg  <= 8'h00;
            toffset_reg <= 8'h00;
        end else if (en_rise) begin
            if (cfg_sel[1]) begin
                target_reg  <= vout_cmd_reg;
                toffset_reg <= offset_reg;
            end else begin
                target_reg  <= vts_boot_code(proto_reg[VTS_PROTO_BOOT_LSB +: 4]);
                // Mode 00 starts with no offset; mode 01 freezes the host one
                toffset_reg <= (cfg_sel == VTS_SRC_VID) ? 8'h00 : offset_reg;
            end
            start_offset_reg <= offset_reg;
        end else if (state_reg == VTS_ST_RUN) begin
            case (mode_reg)
                VTS_SRC_VID: begin
                    if (vid_set) target_reg <= vid_clamped;
                    toffset_reg <= vid_offset_reg;
                end
                VTS_SRC_VID_HOST: begin
                    if (vid_set) target_reg <= vid_clamped;
                    toffset_reg <= start_offset_reg;
                end
                default: begin
                    // One cycle after the accepted write lands
                    target_reg  <= vout_cmd_reg;
                    toffset_reg <= offset_reg;
                end
            endcase
        end
    end

    assign o_target        = target_reg;
    assign o_target_offset = toffset_reg;
    assign o_src_mode      = mode_reg;
    assign o_state         = state_reg;
    assign o_vid_boot      = vid_boot_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_vout_wr_run;
        host_wr && wr_ok && i_host_req.addr == VTS_ADDR_VOUT_CMD && active_mode[1] && state_reg == VTS_ST_RUN;
    endsequence

    sequence s_store_cmd;
        host_wr && i_host_req.addr == VTS_ADDR_STORE_ALL;
    endsequence

    AST_MODE_LATCH: assert property (en_rise |=> mode_reg == $past(cfg_sel))
        else $error("selector not latched at enable rise");
    AST_MODE_HOLD: assert property (en_d_reg && i_en |=> $stable(mode_reg))
        else $error("selector changed while enabled");
    AST_START_BOOT: assert property (en_rise && !cfg_sel[1] |=>
        target_reg == vts_boot_code($past(proto_reg[VTS_PROTO_BOOT_LSB +: 4])))
        else $error("start target not taken from boot field");
    AST_VOUT_DISCARD: assert property (host_wr && i_host_req.addr == VTS_ADDR_VOUT_CMD && !active_mode[1]
        |=> $stable(vout_cmd_reg))
        else $error("target write not discarded in voltage-ID mode");
    AST_OFFSET_NACK: assert property (host_wr && i_host_req.addr == VTS_ADDR_OFFSET && active_mode == VTS_SRC_VID
        |=> o_host_nack && !o_host_ack)
        else $error("offset write not refused in mode 00");
    AST_VID_OFFSET_IGNORE: assert property (vid_take && i_vid_req.kind == VTS_VID_REGWR &&
        active_mode != VTS_SRC_VID |=> $stable(vid_offset_reg) && o_vid_ack)
        else $error("voltage-ID offset not ignored");
    AST_BOOT_COPY: assert property (host_wr && wr_ok && i_host_req.addr == VTS_ADDR_PROTOCOL
        |=> vid_boot_reg == vts_boot_code($past(wr_boot)))
        else $error("boot value not mirrored");
    AST_STORE: assert property (s_store_cmd |=> o_nvm_wr ##1
        o_nvm_wr == $past(host_wr && i_host_req.addr == VTS_ADDR_STORE_ALL))
        else $error("store pulse wrong");
    AST_RESTORE: assert property (!por_done_reg |=> por_done_reg &&
        vid_boot_reg == vts_boot_code($past(i_nvm_image.boot)))
        else $error("boot not restored at power-on");
    AST_START_CMD: assert property (en_rise && cfg_sel[1] |=> target_reg == $past(vout_cmd_reg))
        else $error("host mode start target wrong");
    AST_RANGE: assert property (host_wr && i_host_req.addr == VTS_ADDR_VOUT_CMD &&
        i_host_req.data < VTS_VOUT_MIN_CODE |=> o_host_nack)
        else $error("out-of-range target accepted");
    AST_IMMEDIATE: assert property (s_vout_wr_run ##1 (i_en && state_reg == VTS_ST_RUN)
        |=> target_reg == $past(i_host_req.data, 2))
        else $error("host target not applied");
    AST_BOOT_FIT: assert property (host_wr && i_host_req.addr == VTS_ADDR_PROTOCOL &&
        !vts_boot_fits(wr_boot, wr_step) |=> o_host_nack && $stable(proto_reg))
        else $error("unfit boot value accepted");
    AST_CLAMP: assert property (i_en && !en_rise && state_reg == VTS_ST_RUN && !mode_reg[1] && vid_set
        |=> target_reg <= $past(i_max_id_limit))
        else $error("voltage-ID target above limit");
    AST_VID_ACK: assert property (vid_take |=> o_vid_ack)
        else $error("voltage-ID request not acknowledged");
    AST_OFFSET_FROZEN: assert property (i_en && state_reg == VTS_ST_RUN && mode_reg == VTS_SRC_VID_HOST
        |=> $stable(toffset_reg))
        else $error("mode 01 offset changed while running");
    AST_OFFSET_TRACK: assert property (host_wr && wr_ok && i_host_req.addr == VTS_ADDR_OFFSET
        && active_mode[1] && state_reg == VTS_ST_RUN ##1 (i_en && state_reg == VTS_ST_RUN)
        |=> toffset_reg == $past(i_host_req.data, 2))
        else $error("host offset not applied");
    AST_NO_EARLY_START: assert property (!por_done_reg |=> state_reg == VTS_ST_OFF)
        else $error("conversion started before restore");

endmodule

//--- vts_nvm_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Nonvolatile image store on the far side of the converter
// ****************************************************************
module vts_nvm_model #(
    parameter vts_pkg::vts_nvm_image_type INIT_IMAGE = 22'h09_5003
) (
    // Clock
    input  wire logic                       i_clk_sys,
    // Save request
    input  wire logic                       i_nvm_wr,
    input  wire vts_pkg::vts_nvm_image_type i_nvm_image,
    // Stored image
    output vts_pkg::vts_nvm_image_type      o_nvm_image
);
    import vts_pkg::*;

    // Survives converter resets, like real flash
    initial o_nvm_image = INIT_IMAGE;

    // Keep the snapshot taken on a save pulse
    always @(posedge i_clk_sys) begin
        if (i_nvm_wr === 1'b1) begin
            o_nvm_image <= i_nvm_image;
        end
    end
endmodule

//--- vts_core_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench for the output target source selector
// ****************************************************************
module vts_core_bench;
    import vts_pkg::*;

    logic              i_clk_sys = 1'b0;
    logic              i_nrst    = 1'b0;
    logic              en        = 1'b0;
    logic              ramp      = 1'b0;
    vts_host_req_type  hreq      = '0;
    vts_vid_req_type   vreq      = '0;
    vts_nvm_image_type nvm_img;
    vts_nvm_image_type nvm_wr_img;
    logic              nvm_wr;
    logic              host_ack;
    logic              host_nack;
    logic [7:0]        rdata;
    logic              vid_ack;
    logic [7:0]        vid_boot;
    logic [7:0]        target;
    logic [7:0]        offset;
    vts_src_type       src;
    vts_state_type     state;
    int                error_cnt = 0;
    int                num_checks = 0;
    int                cyc_cnt = 0;

    // 100 MHz clock
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    vts_core dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_en(en), .i_ramp_done(ramp),
        .i_max_id_limit(8'h70), .i_host_req(hreq), .o_host_ack(host_ack), .o_host_nack(host_nack),
        .o_host_rdata(rdata), .i_vid_req(vreq), .o_vid_ack(vid_ack), .o_vid_boot(vid_boot),
        .i_nvm_image(nvm_img), .o_nvm_wr(nvm_wr), .o_nvm_image(nvm_wr_img), .o_target(target),
        .o_target_offset(offset), .o_src_mode(src), .o_state(state));

    vts_nvm_model nvm_u (.i_clk_sys(i_clk_sys), .i_nvm_wr(nvm_wr), .i_nvm_image(nvm_wr_img),
        .o_nvm_image(nvm_img));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic final_report;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // Bounded wait for a one-cycle answer pulse
    task automatic wait_ans(input bit vid);
        int n;
        n = 0;
        #1;
        while ((vid ? vid_ack : (host_ack || host_nack)) !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic hw(input logic [7:0] a, input logic [7:0] d, input logic nk);
        @(posedge i_clk_sys);
        hreq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge i_clk_sys);
        hreq.wr <= 1'b0;
        wait_ans(1'b0);
        chk({6'h00, host_ack, host_nack}, {6'h00, !nk, nk});
    endtask

    task automatic hr(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        hreq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge i_clk_sys);
        hreq.rd <= 1'b0;
        wait_ans(1'b0);
        chk({7'h00, host_ack}, 8'h01);
        chk(rdata, e);
    endtask

    task automatic vc(input vts_vid_kind_type k, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        vreq <= '{kind: k, addr: a, data: d};
        @(posedge i_clk_sys);
        vreq.kind <= VTS_VID_NONE;
        wait_ans(1'b1);
        chk({7'h00, vid_ack}, 8'h01);
    endtask

    // Disable, pick source, preset offset, then enable and finish the ramp
    task automatic power(input logic [1:0] cfg, input logic [7:0] off);
        @(posedge i_clk_sys);
        en <= 1'b0;
        ramp <= 1'b0;
        cyc(2);
        hw(8'hA0, {6'h00, cfg}, 1'b0);
        hw(8'hA8, off, cfg == 2'b00);
        @(posedge i_clk_sys);
        en <= 1'b1;
        cyc(2);
        chk({6'h00, state}, 8'h01);
        chk({6'h00, src}, {6'h00, cfg});
        @(posedge i_clk_sys);
        ramp <= 1'b1;
        cyc(2);
        chk({6'h00, state}, 8'h03);
    endtask

    // ****************************************************************
    // Hang guard and test sequence
    // ****************************************************************
    always @(posedge i_clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        cyc(3);
        chk(vid_boot, 8'h6F);
        hr(8'hC2, 8'h21);
        hw(8'hC2, 8'h31, 1'b0);
        cyc(1);
        chk(vid_boot, 8'h79);
        hw(8'hC2, 8'hF1, 1'b1);
        hw(8'h10, 8'h00, 1'b1);
        power(2'b00, 8'h09);
        chk(target, 8'h79);
        hw(8'hA6, 8'h22, 1'b0);
        hr(8'hA6, 8'h50);
        // Set commands only after the ramp ends
        vc(VTS_VID_SETV, 8'h00, 8'h80);
        cyc(2);
        chk(target, 8'h70);
        vc(VTS_VID_SET_WORKING_POINT_CMD, 8'h00, 8'h60);
        cyc(2);
        chk(target, 8'h60);
        vc(VTS_VID_REGWR, 8'h33, 8'h05);
        cyc(2);
        chk(offset, 8'h05);
        hw(8'hA0, 8'h02, 1'b0);
        cyc(2);
        chk({6'h00, src}, 8'h00);
        power(2'b10, 8'h04);
        chk(target, 8'h50);
        chk(offset, 8'h04);
        hw(8'hA6, 8'h40, 1'b0);
        cyc(2);
        chk(target, 8'h40);
        hw(8'hA8, 8'h07, 1'b0);
        cyc(2);
        chk(offset, 8'h07);
        vc(VTS_VID_SETV, 8'h00, 8'h30);
        vc(VTS_VID_REGWR, 8'h33, 8'h0B);
        cyc(2);
        chk(target, 8'h40);
        chk(offset, 8'h07);
        hw(8'hA6, 8'h00, 1'b1);
        hw(8'h15, 8'h00, 1'b0);
        cyc(2);
        chk(nvm_img.vout_cmd, 8'h40);
        chk(nvm_img.offset, 8'h07);
        chk({nvm_img.boot, 2'b00, nvm_img.step}, 8'h31);
        power(2'b01, 8'h09);
        chk(target, 8'h79);
        chk(offset, 8'h09);
        hw(8'hA8, 8'h0A, 1'b0);
        vc(VTS_VID_REGWR, 8'h33, 8'h0B);
        hw(8'hA6, 8'h55, 1'b0);
        cyc(2);
        chk(offset, 8'h09);
        chk(target, 8'h79);
        // Second power-on restores the saved image
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        cyc(2);
        @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        cyc(3);
        chk(vid_boot, 8'h79);
        chk(target, 8'h79);
        power(2'b11, 8'h02);
        chk(target, 8'h40);
        chk(offset, 8'h02);
        hw(8'hC2, 8'hD0, 1'b0);
        hw(8'hA6, 8'hFF, 1'b0);
        cyc(2);
        chk(target, 8'hFF);
        final_report();
    end
endmodule
